//--- src/fco_fault_code_unit.sv
// Fault code terminals, trip selection and register slave
// Functional notes
// - Mode 0 no code, 1 continuous code, 2 code only on fault; reset 0.
// - Mode 2 without fault: terminals carry their ordinary assigned signals.
// - Code bits on four terminals, start terminal MSB, frequency LSB.
// - Code bit 1 turns the output transistor on, 0 leaves it off.
// - Codes 0 normal, 1-3 overcurrent, 4 overvoltage, 5-7 thermal/power.
// - Codes 8 to E for listed faults; every other fault gives F.
// - Nonzero mode shows the fault code regardless of terminal functions.
// - Output phase-loss trip enabled by select bit, reset 1.
// - Input phase loss of one phase for 1 s trips when enabled.
// - With power-fail stop set, input phase loss starts power-fail decel.
// - Loss of first and second phases shuts output off without trip.
// - Vector or encoder control: speed at or above level trips; reset 140 Hz.
// - Sensorless control compares commanded frequency with the level.
// - Encoder loss under vector or encoder control trips when enabled; reset off.
// - Definition 0: every fault shuts output at once and asserts fault.
// - Definition 1: motor thermal decelerates first, faults once stopped.
// - Decel mode thermal faults raise minor flag; others shut off at once.
// - Decelerate-before-trip is suppressed during position control.
//
// The placing of the registers and the Avalon-MM interface to the registers were decided locally.
`include "fco_params.svh"
module fco_fault_code_unit #(
   parameter int unsigned ILF_CYCLES = `FCO_ILF_CYCLES
) (
   input wire logic clk,
   input wire logic arst_n,
   input wire logic [`FCO_AW-1:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   output logic [31:0] avs_readdata,
   output logic avs_waitrequest,
   input wire logic [`FCO_NEXT-1:0] faultReq,
   input wire logic outPhaseOpen,
   input wire logic [2:0] inPhaseLost,
   input wire fco_pkg::fco_ctrl_t ctrlMode,
   input wire logic [`FCO_OSPD_W-1:0] motorSpeed,
   input wire logic [`FCO_OSPD_W-1:0] cmdFreq,
   input wire logic encoderLost,
   input wire logic motorStopped,
   input wire logic positionCtrl,
   input wire logic [3:0] termFunc,
   output logic [3:0] codeTerm,
   output logic faultOut,
   output logic minorFault,
   output logic decelReq,
   output logic outputShutoff,
   output logic powerFailDecel
);
   import fco_pkg::*;

   // ****************************************
   // Code lookup
   // ****************************************
   // Lowest source index wins when several faults arrive together
   function automatic logic [3:0] codeOf(input logic [`FCO_NSRC-1:0] v);
      logic [3:0] c;
      logic [59:0] tbl;
      c = `FCO_CODE_NORMAL;
      tbl = `FCO_CODE_TABLE;
      for (int i = `FCO_NSRC - 1; i >= 0; i--) begin
         if (v[i]) begin
            c = (i < `FCO_NTBL) ? tbl[i*4 +: 4] : `FCO_CODE_OTHER;
         end
      end
      return c;
   endfunction

   // ****************************************
   // Registers and bus
   // ****************************************
   logic [1:0] mode, next_mode;
   logic oplEn, next_oplEn;
   logic iplEn, next_iplEn;
   logic encEn, next_encEn;
   logic faultDef, next_faultDef;
   logic pfStop, next_pfStop;
   logic [`FCO_OSPD_W-1:0] ospdLevel, next_ospdLevel;
   logic [31:0] next_avs_readdata;
   logic next_avs_waitrequest;
   logic busReq, wrDone, clearReq;
   logic [3:0] faultCode, next_faultCode;
   fco_state_t state, next_state;

   assign busReq = avs_read | avs_write;
   assign wrDone = avs_write & ~avs_waitrequest;
   assign clearReq = wrDone && avs_address == `FCO_ADDR_CLR &&
      avs_writedata[`FCO_CLR_BIT];

   always_comb begin
      next_mode = mode;
      next_oplEn = oplEn;
      next_iplEn = iplEn;
      next_encEn = encEn;
      next_faultDef = faultDef;
      next_pfStop = pfStop;
      next_ospdLevel = ospdLevel;
      // One wait state: answer in the cycle after the request is seen
      next_avs_waitrequest = ~(busReq & avs_waitrequest);
      next_avs_readdata = avs_readdata;
      if (busReq && avs_waitrequest) begin
         next_avs_readdata = '0;
         case (avs_address)
            `FCO_ADDR_CTRL: begin
               next_avs_readdata[`FCO_CTRL_MODE] = mode;
               next_avs_readdata[`FCO_CTRL_OPL] = oplEn;
               next_avs_readdata[`FCO_CTRL_IPL] = iplEn;
               next_avs_readdata[`FCO_CTRL_ENC] = encEn;
               next_avs_readdata[`FCO_CTRL_FDEF] = faultDef;
               next_avs_readdata[`FCO_CTRL_PFS] = pfStop;
            end
            `FCO_ADDR_OSPD: next_avs_readdata[`FCO_OSPD_W-1:0] = ospdLevel;
            `FCO_ADDR_STAT: begin
               next_avs_readdata[`FCO_STAT_CODE] = faultCode;
               next_avs_readdata[`FCO_STAT_FOUT] = faultOut;
               next_avs_readdata[`FCO_STAT_MINOR] = minorFault;
               next_avs_readdata[`FCO_STAT_DECEL] = decelReq;
               next_avs_readdata[`FCO_STAT_SHUT] = outputShutoff;
               next_avs_readdata[`FCO_STAT_PFD] = powerFailDecel;
            end
            default: next_avs_readdata = '0;
         endcase
      end
      if (wrDone) begin
         case (avs_address)
            `FCO_ADDR_CTRL: begin
               // Unsupported mode value is ignored
               if (avs_writedata[`FCO_CTRL_MODE] != `FCO_MODE_BAD) begin
                  next_mode = avs_writedata[`FCO_CTRL_MODE];
               end
               next_oplEn = avs_writedata[`FCO_CTRL_OPL];
               next_iplEn = avs_writedata[`FCO_CTRL_IPL];
               next_encEn = avs_writedata[`FCO_CTRL_ENC];
               next_faultDef = avs_writedata[`FCO_CTRL_FDEF];
               next_pfStop = avs_writedata[`FCO_CTRL_PFS];
            end
            `FCO_ADDR_OSPD: begin
               // Clamp to the top of the setting range
               if (avs_writedata[`FCO_OSPD_W-1:0] > `FCO_OSPD_MAX ||
                   avs_writedata[31:`FCO_OSPD_W] != '0) begin
                  next_ospdLevel = `FCO_OSPD_MAX;
               end else begin
                  next_ospdLevel = avs_writedata[`FCO_OSPD_W-1:0];
               end
            end
            default: begin
            end
         endcase
      end
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         mode <= `FCO_MODE_RST;
         oplEn <= `FCO_OPL_RST;
         iplEn <= 1'b0;
         encEn <= 1'b0;
         faultDef <= 1'b0;
         pfStop <= 1'b0;
         ospdLevel <= `FCO_OSPD_RST;
         avs_readdata <= '0;
         avs_waitrequest <= 1'b1;
      end else begin
         mode <= next_mode;
         oplEn <= next_oplEn;
         iplEn <= next_iplEn;
         encEn <= next_encEn;
         faultDef <= next_faultDef;
         pfStop <= next_pfStop;
         ospdLevel <= next_ospdLevel;
         avs_readdata <= next_avs_readdata;
         avs_waitrequest <= next_avs_waitrequest;
      end
   end

   // ****************************************
   // Trip detection
   // ****************************************
   logic [`FCO_ILF_W-1:0] ilfCnt, next_ilfCnt;
   logic anyLost, rsLost, ilfHit, ospdHit, encHit, oplHit;
   logic [`FCO_NSRC-1:0] src;
   logic decelStart, anyFault, otherFault;

   assign anyLost = |inPhaseLost;
   assign rsLost = inPhaseLost[0] & inPhaseLost[1];
   // Saturated count alone must not trip once the loss has gone
   assign ilfHit = iplEn && anyLost && !rsLost &&
      ilfCnt == `FCO_ILF_W'(ILF_CYCLES - 1);
   assign oplHit = oplEn & outPhaseOpen;
   always_comb begin
      case (ctrlMode)
         FCO_CM_VECTOR, FCO_CM_ENCODER: ospdHit = motorSpeed >= ospdLevel;
         FCO_CM_SENSORLESS: ospdHit = cmdFreq >= ospdLevel;
         default: ospdHit = 1'b0;
      endcase
   end
   assign encHit = encEn & encoderLost &
      (ctrlMode == FCO_CM_ENCODER || ctrlMode == FCO_CM_VECTOR);
   // Power-fail stop diverts input phase loss away from the trip
   assign src = {encHit, ospdHit, ilfHit & ~pfStop, oplHit, faultReq};
   assign anyFault = |src;
   assign otherFault = |(src & ~`FCO_DECEL_MASK);
   assign decelStart = faultDef & ~positionCtrl & ~otherFault &
      |(src & `FCO_DECEL_MASK);

   always_comb begin
      // Continuous loss only: any gap restarts the count
      if (iplEn && anyLost && !rsLost) begin
         next_ilfCnt = ilfHit ? ilfCnt : ilfCnt + 1'b1;
      end else begin
         next_ilfCnt = '0;
      end
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         ilfCnt <= '0;
      end else begin
         ilfCnt <= next_ilfCnt;
      end
   end

   // ****************************************
   // Fault sequencing and terminals
   // ****************************************
   logic next_faultOut, next_minorFault, next_decelReq;
   logic next_outputShutoff, next_powerFailDecel;
   logic [3:0] next_codeTerm;

   always_comb begin
      next_state = state;
      next_faultCode = faultCode;
      case (state)
         FCO_IDLE: begin
            if (decelStart) begin
               next_state = FCO_DECEL;
               next_faultCode = codeOf(src);
            end else if (anyFault) begin
               next_state = FCO_TRIP;
               next_faultCode = codeOf(src);
            end
         end
         FCO_DECEL: begin
            if (otherFault) begin
               next_state = FCO_TRIP;
               next_faultCode = codeOf(src & ~`FCO_DECEL_MASK);
            end else if (motorStopped) begin
               next_state = FCO_TRIP;
            end
         end
         FCO_TRIP: begin
            if (clearReq) begin
               next_state = FCO_IDLE;
               next_faultCode = `FCO_CODE_NORMAL;
            end
         end
         default: next_state = FCO_IDLE;
      endcase
      next_faultOut = next_state == FCO_TRIP;
      next_minorFault = next_state == FCO_DECEL;
      next_decelReq = next_state == FCO_DECEL;
      next_outputShutoff = next_state == FCO_TRIP || rsLost;
      next_powerFailDecel = (powerFailDecel & ~clearReq) |
         (ilfHit & pfStop);
      // Bit 3 start, 2 power-fail, 1 overload, 0 frequency terminal
      case (mode)
         `FCO_MODE_CONT: next_codeTerm = next_faultCode;
         `FCO_MODE_FAULT: next_codeTerm = (next_state == FCO_TRIP) ?
            next_faultCode : termFunc;
         default: next_codeTerm = termFunc;
      endcase
   end

   // High on codeTerm turns the terminal transistor on
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         state <= FCO_IDLE;
         faultCode <= `FCO_CODE_NORMAL;
         faultOut <= 1'b0;
         minorFault <= 1'b0;
         decelReq <= 1'b0;
         outputShutoff <= 1'b0;
         powerFailDecel <= 1'b0;
         codeTerm <= '0;
      end else begin
         state <= next_state;
         faultCode <= next_faultCode;
         faultOut <= next_faultOut;
         minorFault <= next_minorFault;
         decelReq <= next_decelReq;
         outputShutoff <= next_outputShutoff;
         powerFailDecel <= next_powerFailDecel;
         codeTerm <= next_codeTerm;
      end
   end

   // ****************************************
   // Checks
   // ****************************************
   default clocking @(posedge clk); endclocking
   default disable iff (!arst_n);

   chk_mode_zero_pass: assert property (
      mode == `FCO_MODE_RST && next_mode == mode |=> codeTerm == $past(termFunc))
      else $error("mode 0 terminals not ordinary");
   chk_mode_two_normal: assert property (
      mode == `FCO_MODE_FAULT && next_mode == mode && next_state != FCO_TRIP
      |=> codeTerm == $past(termFunc))
      else $error("mode 2 normal terminals wrong");
   chk_code_on_trip: assert property (
      state == FCO_TRIP && !clearReq && mode != `FCO_MODE_RST
      |=> codeTerm == $past(faultCode))
      else $error("fault code not on terminals");
   chk_normal_code_zero: assert property (
      mode == `FCO_MODE_CONT && next_mode == mode && state == FCO_IDLE &&
      !anyFault |=> codeTerm == `FCO_CODE_NORMAL)
      else $error("normal code not zero");
   chk_immediate_trip: assert property (
      !faultDef && state == FCO_IDLE && anyFault
      |=> state == FCO_TRIP && faultOut && outputShutoff)
      else $error("fault did not trip at once");
   chk_decel_start: assert property (
      state == FCO_IDLE && decelStart
      |=> state == FCO_DECEL && minorFault && decelReq && !faultOut)
      else $error("thermal fault did not decelerate");
   chk_decel_stop_trip: assert property (
      state == FCO_DECEL && motorStopped |=> faultOut ##0 !minorFault)
      else $error("no fault after stop");
   chk_pos_no_decel: assert property (
      positionCtrl && state == FCO_IDLE |=> state != FCO_DECEL)
      else $error("decel during position control");
   chk_ilf_count: assert property (
      ilfHit |-> iplEn && anyLost && $past(anyLost))
      else $error("input phase trip without loss");
   chk_rs_no_trip: assert property (
      rsLost |-> !ilfHit ##1 outputShutoff)
      else $error("phase 1 and 2 loss handled wrong");
   chk_ospd_trip: assert property (
      state == FCO_IDLE && ctrlMode == FCO_CM_VECTOR &&
      motorSpeed >= ospdLevel && !decelStart |=> state == FCO_TRIP)
      else $error("overspeed did not trip");
   chk_hold_code: assert property (
      state == FCO_TRIP && !clearReq |=> state == FCO_TRIP && $stable(faultCode))
      else $error("fault code not held");
   cov_decel_then_trip: cover property (
      state == FCO_DECEL ##[1:50] state == FCO_TRIP);
   cov_ilf_trip: cover property (ilfHit && !pfStop);
   cov_pf_decel: cover property (powerFailDecel);
   cov_mode_two_code: cover property (mode == `FCO_MODE_FAULT &&
      state == FCO_TRIP);
endmodule

//--- src/fco_params.svh
// Constants for the fault code output and trip select unit
`ifndef FCO_PARAMS_SVH
`define FCO_PARAMS_SVH
// ****************************************
// Register map (byte addresses)
// ****************************************
`define FCO_AW 4
`define FCO_ADDR_CTRL 4'h0
`define FCO_ADDR_OSPD 4'h4
`define FCO_ADDR_STAT 4'h8
`define FCO_ADDR_CLR 4'hC
// CTRL fields
`define FCO_CTRL_MODE 1:0
`define FCO_CTRL_OPL 2
`define FCO_CTRL_IPL 3
`define FCO_CTRL_ENC 4
`define FCO_CTRL_FDEF 5
`define FCO_CTRL_PFS 6
`define FCO_CLR_BIT 0
// STAT fields
`define FCO_STAT_CODE 3:0
`define FCO_STAT_FOUT 4
`define FCO_STAT_MINOR 5
`define FCO_STAT_DECEL 6
`define FCO_STAT_SHUT 7
`define FCO_STAT_PFD 8
// Mode encodings and reset values
`define FCO_MODE_RST 2'h0
`define FCO_MODE_CONT 2'h1
`define FCO_MODE_FAULT 2'h2
`define FCO_MODE_BAD 2'h3
`define FCO_OPL_RST 1'b1
// Overspeed level in 0.1 Hz units
`define FCO_OSPD_W 12
`define FCO_OSPD_RST 12'h0_578
`define FCO_OSPD_MAX 12'h0_FA0
// ****************************************
// Fault sources and codes
// ****************************************
`define FCO_NEXT 17
`define FCO_NSRC 21
`define FCO_NTBL 15
`define FCO_CODE_NORMAL 4'h0
`define FCO_CODE_OTHER 4'hF
// Codes for sources 0..14, source 0 in the low nibble
`define FCO_CODE_TABLE 60'hEED_CBA9_8765_4321
// Motor thermal, external thermal, thermistor sources
`define FCO_DECEL_MASK 21'h0_8810
// ****************************************
// Timing
// ****************************************
`define FCO_CLK_HZ 40_000_000
`define FCO_ILF_TIME_MS 1000
`define FCO_ILF_CYCLES (`FCO_CLK_HZ / 1000 * `FCO_ILF_TIME_MS)
`define FCO_ILF_W 26
`endif

//--- src/fco_pkg.sv
// Types for the fault code output and trip select unit
package fco_pkg;
   typedef enum logic [1:0] {
      FCO_CM_VF,
      FCO_CM_SENSORLESS,
      FCO_CM_VECTOR,
      FCO_CM_ENCODER
   } fco_ctrl_t;
   typedef enum logic [1:0] {FCO_IDLE, FCO_DECEL, FCO_TRIP} fco_state_t;
endpackage

//--- tb/fco_code_reader.sv
// Controller model that reads the four fault code terminals
module fco_code_reader (
   input wire logic clk,
   input wire logic arst_n,
   input wire logic [3:0] codeTerm,
   output logic [3:0] readCode
);
   timeunit 1ns;
   timeprecision 1ps;
   // ******************
   // Terminal sampling
   // ******************
   logic [3:0] next_readCode;
   always_comb begin
      // On transistor reads 1, start terminal first
      next_readCode = {codeTerm[3], codeTerm[2], codeTerm[1], codeTerm[0]};
   end
   // Sampled once a cycle, as a scanning controller would
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         readCode <= 4'h0;
      end else begin
         readCode <= next_readCode;
      end
   end
endmodule

//--- tb/test_fco_fault_code_unit.sv
// Testbench of the fault code output and trip select unit
`include "fco_params.svh"
`define CHK(a, b) begin nTests++; if ((a) !== (b)) begin errTotal++; \
   $display("Error at %0t: got %h expected %h", $time, a, b); end end
module test_fco_fault_code_unit;
   timeunit 1ns;
   timeprecision 1ps;
   import fco_pkg::*;
   // ******************
   // Signals
   // ******************
   localparam int ILF = 20;
   logic clk = 1'b0;
   logic arst_n = 1'b0;
   logic [3:0] busAddr = 4'h0;
   logic busRd = 1'b0;
   logic busWr = 1'b0;
   logic [31:0] busWd = 32'h0000_0000;
   logic [31:0] busRdata, got;
   logic busWait, faultOut, minorFault, decelReq, outputShutoff;
   logic powerFailDecel;
   logic [16:0] faultReq = 17'h0_0000;
   logic outPhaseOpen = 1'b0;
   logic [2:0] inPhaseLost = 3'h0;
   fco_ctrl_t ctrlMode = FCO_CM_VF;
   logic [11:0] motorSpeed = 12'h000;
   logic [11:0] cmdFreq = 12'h000;
   logic encoderLost = 1'b0;
   logic motorStopped = 1'b0;
   logic positionCtrl = 1'b0;
   logic [3:0] termFunc = 4'h9;
   logic [3:0] codeTerm, readCode;
   logic [3:0] codes [17] = '{4'h1, 4'h2, 4'h3, 4'h4, 4'h5, 4'h6, 4'h7,
      4'h8, 4'h9, 4'hA, 4'hB, 4'hC, 4'hD, 4'hE, 4'hE, 4'hF, 4'hF};
   int errTotal = 0;
   int nTests = 0;
   int cycles = 0;
   fco_fault_code_unit #(.ILF_CYCLES(ILF)) fco_fault_code_unit_i (
      .clk(clk), .arst_n(arst_n), .avs_address(busAddr),
      .avs_read(busRd), .avs_write(busWr), .avs_writedata(busWd),
      .avs_readdata(busRdata), .avs_waitrequest(busWait),
      .faultReq(faultReq), .outPhaseOpen(outPhaseOpen),
      .inPhaseLost(inPhaseLost), .ctrlMode(ctrlMode),
      .motorSpeed(motorSpeed), .cmdFreq(cmdFreq),
      .encoderLost(encoderLost), .motorStopped(motorStopped),
      .positionCtrl(positionCtrl), .termFunc(termFunc),
      .codeTerm(codeTerm), .faultOut(faultOut), .minorFault(minorFault),
      .decelReq(decelReq), .outputShutoff(outputShutoff),
      .powerFailDecel(powerFailDecel));
   fco_code_reader fco_code_reader_i (
      .clk(clk), .arst_n(arst_n), .codeTerm(codeTerm),
      .readCode(readCode));
   always #12.5 clk = ~clk;
   // Run normally ends near 500 cycles
   always @(posedge clk) begin
      cycles++;
      if (cycles == 20000) begin
         errTotal++;
         completeRun();
      end
   end
   // ******************
   // Tasks
   // ******************
   task automatic completeRun();
      $display("Comparisons %0d, mismatches %0d", nTests, errTotal);
      if (errTotal == 0 && nTests > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask
   task automatic cyc(input int n);
      repeat (n) @(negedge clk);
   endtask
   // Request held until waitrequest is sampled low at a rising edge
   task automatic busXfer(input logic w, input logic [3:0] a,
         input logic [31:0] d);
      @(posedge clk);
      busAddr <= a;
      busWr <= w;
      busRd <= !w;
      busWd <= d;
      do begin
         @(posedge clk);
      end while (busWait !== 1'b0);
      got = busRdata;
      busWr <= 1'b0;
      busRd <= 1'b0;
   endtask
   task automatic rdChk(input logic [3:0] a, input logic [31:0] e);
      busXfer(1'b0, a, 32'h0000_0000);
      `CHK(got, e)
   endtask
   // Checks the outcome, drops every source, then clears the fault
   task automatic outcome(input logic f, input logic [3:0] c,
         input logic [3:0] idle);
      cyc(4);
      `CHK(faultOut, f)
      `CHK(outputShutoff, f)
      `CHK(readCode, f ? c : idle)
      @(posedge clk);
      faultReq <= 17'h0_0000;
      outPhaseOpen <= 1'b0;
      inPhaseLost <= 3'h0;
      encoderLost <= 1'b0;
      motorSpeed <= 12'h000;
      cmdFreq <= 12'h000;
      motorStopped <= 1'b0;
      busXfer(1'b1, `FCO_ADDR_CLR, 32'h0000_0001);
      cyc(3);
      `CHK(faultOut, 1'b0)
      `CHK(readCode, idle)
   endtask
   // ******************
   // Tests
   // ******************
   initial begin
      repeat (16) @(posedge clk);
      arst_n <= 1'b1;
      // Reader adds one cycle behind the terminal flip-flops
      cyc(3);
      `CHK(readCode, 4'h9)
      rdChk(`FCO_ADDR_CTRL, 32'h0000_0004);
      rdChk(`FCO_ADDR_OSPD, 32'h0000_0578);
      rdChk(4'h2, 32'h0000_0000);
      @(posedge clk);
      faultReq <= 17'h0_0001;
      outcome(1'b1, 4'h9, 4'h9);
      busXfer(1'b1, `FCO_ADDR_CTRL, 32'h0000_0005);
      for (int i = 0; i < 17; i++) begin
         @(posedge clk);
         faultReq <= 17'h0_0001 << i;
         outcome(1'b1, codes[i], 4'h0);
      end
      // Two sources together: lower index wins, code kept in STAT
      @(posedge clk);
      faultReq <= 17'h0_0088;
      rdChk(`FCO_ADDR_STAT, 32'h0000_0094);
      outcome(1'b1, 4'h4, 4'h0);
      busXfer(1'b1, `FCO_ADDR_CTRL, 32'h0000_0006);
      termFunc <= 4'h5;
      cyc(3);
      `CHK(readCode, 4'h5)
      @(posedge clk);
      faultReq <= 17'h0_1000;
      outcome(1'b1, 4'hD, 4'h5);
      busXfer(1'b1, `FCO_ADDR_CTRL, 32'h0000_0007);
      rdChk(`FCO_ADDR_CTRL, 32'h0000_0006);
      busXfer(1'b1, `FCO_ADDR_CTRL, 32'h0000_0005);
      outPhaseOpen <= 1'b1;
      outcome(1'b1, 4'hF, 4'h0);
      busXfer(1'b1, `FCO_ADDR_CTRL, 32'h0000_0001);
      outPhaseOpen <= 1'b1;
      outcome(1'b0, 4'hF, 4'h0);
      // A loss just short of the time, then a gap, restarts the count
      busXfer(1'b1, `FCO_ADDR_CTRL, 32'h0000_000D);
      inPhaseLost <= 3'h4;
      repeat (ILF - 4) @(posedge clk);
      inPhaseLost <= 3'h0;
      cyc(3);
      `CHK(faultOut, 1'b0)
      @(posedge clk);
      inPhaseLost <= 3'h2;
      cyc(ILF);
      outcome(1'b1, 4'hF, 4'h0);
      @(posedge clk);
      inPhaseLost <= 3'h3;
      cyc(ILF + 4);
      `CHK(outputShutoff, 1'b1)
      `CHK(faultOut, 1'b0)
      @(posedge clk);
      inPhaseLost <= 3'h0;
      outcome(1'b0, 4'hF, 4'h0);
      busXfer(1'b1, `FCO_ADDR_CTRL, 32'h0000_004D);
      inPhaseLost <= 3'h1;
      cyc(ILF + 2);
      `CHK(powerFailDecel, 1'b1)
      outcome(1'b0, 4'hF, 4'h0);
      `CHK(powerFailDecel, 1'b0)
      busXfer(1'b1, `FCO_ADDR_OSPD, 32'h0000_0FFF);
      rdChk(`FCO_ADDR_OSPD, 32'h0000_0FA0);
      busXfer(1'b1, `FCO_ADDR_OSPD, 32'h0000_0064);
      for (int m = 0; m < 4; m++) begin
         @(posedge clk);
         ctrlMode <= fco_ctrl_t'(m);
         motorSpeed <= (m == 1) ? 12'h000 : 12'h064;
         cmdFreq <= (m == 1) ? 12'h064 : 12'h000;
         outcome(logic'(m != 0), 4'hF, 4'h0);
      end
      @(posedge clk);
      motorSpeed <= 12'h063;
      outcome(1'b0, 4'hF, 4'h0);
      busXfer(1'b1, `FCO_ADDR_CTRL, 32'h0000_0015);
      encoderLost <= 1'b1;
      outcome(1'b1, 4'hF, 4'h0);
      busXfer(1'b1, `FCO_ADDR_CTRL, 32'h0000_0005);
      encoderLost <= 1'b1;
      outcome(1'b0, 4'hF, 4'h0);
      busXfer(1'b1, `FCO_ADDR_CTRL, 32'h0000_0025);
      faultReq <= 17'h0_0010;
      cyc(4);
      `CHK(minorFault, 1'b1)
      `CHK(decelReq, 1'b1)
      `CHK(faultOut, 1'b0)
      @(posedge clk);
      motorStopped <= 1'b1;
      outcome(1'b1, 4'h5, 4'h0);
      `CHK(minorFault, 1'b0)
      @(posedge clk);
      faultReq <= 17'h0_0001;
      outcome(1'b1, 4'h1, 4'h0);
      @(posedge clk);
      positionCtrl <= 1'b1;
      faultReq <= 17'h0_0800;
      outcome(1'b1, 4'hC, 4'h0);
      completeRun();
   end
endmodule
